// [rcr_pkg.sv]
package rcr_pkg;

   // -----------------------------------------------------------------
   // register offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] RCR_ADDR_BUCK_TWO_CONTROL = 8'h32;
   localparam logic [7:0] RCR_ADDR_BUCK_THREE_VOLTAGE_PRIMARY = 8'h40;
   localparam logic [7:0] RCR_ADDR_BUCK_THREE_VOLTAGE_SECONDARY = 8'h41;
   localparam logic [7:0] RCR_ADDR_BUCK_THREE_CONTROL = 8'h42;
   localparam logic [7:0] RCR_ADDR_LINEAR_ONE_VOLTAGE = 8'h50;
   localparam logic [7:0] RCR_ADDR_LINEAR_ONE_CONTROL = 8'h51;

   // -----------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------
   localparam int RCR_BIT_ON = 7;
   localparam int RCR_BIT_PHASE = 6;
   localparam int RCR_BIT_PB_OPTION = 6;
   localparam int RCR_BIT_DISCHARGE = 6;
   localparam int RCR_BIT_MODE = 5;
   localparam int RCR_BIT_LOW_IQ = 5;
   localparam int RCR_DELAY_MSB = 4;
   localparam int RCR_DELAY_LSB = 2;
   localparam int RCR_BIT_FAULT_IRQ = 1;
   localparam int RCR_BIT_POWER_OK = 0;
   localparam int RCR_VCODE_W = 6;
   localparam int RCR_DELAY_W = 3;

   // control bytes keep bits 7:1 writable, voltage bytes bits 5:0
   localparam logic [7:0] RCR_CTRL_WMASK = 8'hFE;
   localparam logic [7:0] RCR_VOLTAGE_SELECT_PIN_WMASK = 8'h3F;

   // -----------------------------------------------------------------
   // reset values (power-up defaults, writable bits only)
   // -----------------------------------------------------------------
   localparam logic [7:0] RCR_RST_BUCK_TWO_CONTROL = 8'h00;
   localparam logic [7:0] RCR_RST_BUCK_THREE_VOLTAGE_PRIMARY = 8'h00;
   localparam logic [7:0] RCR_RST_BUCK_THREE_VOLTAGE_SECONDARY = 8'h00;
   localparam logic [7:0] RCR_RST_BUCK_THREE_CONTROL = 8'h00;
   localparam logic [7:0] RCR_RST_LINEAR_ONE_VOLTAGE = 8'h00;
   localparam logic [7:0] RCR_RST_LINEAR_ONE_CONTROL = 8'h00;

   // -----------------------------------------------------------------
   // access states
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      RCR_ST_IDLE  = 2'b00,
      RCR_ST_WRITE = 2'b01,
      RCR_ST_READ  = 2'b10
   } rcr_state_type;

endpackage

// [rcr_sync.sv]
`timescale 1ns/1ps
module rcr_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   // -----------------------------------------------------------------
   // two-stage synchroniser; the first stage feeds only the second
   // -----------------------------------------------------------------
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] meta_nxt;
   logic [WIDTH-1:0] sync_r;
   logic [WIDTH-1:0] sync_nxt;

   always_comb begin
      meta_nxt = async_in;
      sync_nxt = meta_r;
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end

   assign sync_out = sync_r;

endmodule

// [rcr_regs.sv]
`timescale 1ns/1ps
module rcr_regs
   import rcr_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int DATA_W = 8
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   output logic [DATA_W-1:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic undervoltage_lockout,
   input wire logic voltage_select_pin,
   input wire logic pushbutton_input_n,
   input wire logic [2:0] power_ok_in,
   input wire logic [2:0] fault_in,
   output logic step_down_two_enable,
   output logic step_down_two_phase_180,
   output logic step_down_two_force_pwm,
   output logic [RCR_DELAY_W-1:0] step_down_two_delay,
   output logic step_down_three_enable,
   output logic step_down_three_force_pwm,
   output logic [RCR_DELAY_W-1:0] step_down_three_delay,
   output logic [RCR_VCODE_W-1:0] step_down_three_voltage_code,
   output logic linear_one_enable,
   output logic linear_one_discharge,
   output logic linear_one_low_quiescent,
   output logic [RCR_DELAY_W-1:0] linear_one_delay,
   output logic [RCR_VCODE_W-1:0] linear_one_voltage_code,
   output logic fault_irq
);

   // -----------------------------------------------------------------
   // pin synchronisation
   // -----------------------------------------------------------------
   localparam int SYNC_W = 9;
   logic undervoltage_lockout_s;
   logic voltage_select_pin_s;
   logic pb_s;
   logic [2:0] pok_s;
   logic [2:0] flt_s;

   // button is inverted ahead of the flops: their reset value of zero then
   // means released, so leaving reset never looks like a press
   rcr_sync #(
      .WIDTH(SYNC_W)
   ) u_sync (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .async_in({fault_in, power_ok_in, ~pushbutton_input_n, voltage_select_pin,
                 undervoltage_lockout}),
      .sync_out({flt_s, pok_s, pb_s, voltage_select_pin_s, undervoltage_lockout_s})
   );

   // -----------------------------------------------------------------
   // decode helpers
   // -----------------------------------------------------------------
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
      hit = (a == ADDR_W'(off));
   endfunction

   // keep read-only bits of old, take writable bits of new
   function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                        input logic [7:0] wmask);
      merge = (old_v & ~wmask) | (new_v & wmask);
   endfunction

   // -----------------------------------------------------------------
   // register storage
   // -----------------------------------------------------------------
   logic [7:0] b2_ctrl_r;
   logic [7:0] b2_ctrl_nxt;
   logic [7:0] b3_vpri_r;
   logic [7:0] b3_vpri_nxt;
   logic [7:0] b3_vsec_r;
   logic [7:0] b3_vsec_nxt;
   logic [7:0] b3_ctrl_r;
   logic [7:0] b3_ctrl_nxt;
   logic [7:0] l1_volt_r;
   logic [7:0] l1_volt_nxt;
   logic [7:0] l1_ctrl_r;
   logic [7:0] l1_ctrl_nxt;
   logic [7:0] wbyte;

   assign wbyte = reg_wdata[7:0];

   always_comb begin
      b2_ctrl_nxt = b2_ctrl_r;
      b3_vpri_nxt = b3_vpri_r;
      b3_vsec_nxt = b3_vsec_r;
      b3_ctrl_nxt = b3_ctrl_r;
      l1_volt_nxt = l1_volt_r;
      l1_ctrl_nxt = l1_ctrl_r;
      if (reg_wr_en) begin
         // control bit 0 is status and voltage bits 7:6 reserved
         if (hit(reg_addr, RCR_ADDR_BUCK_TWO_CONTROL)) begin
            b2_ctrl_nxt = merge(b2_ctrl_r, wbyte, RCR_CTRL_WMASK);
         end
         if (hit(reg_addr, RCR_ADDR_BUCK_THREE_VOLTAGE_PRIMARY)) begin
            b3_vpri_nxt = merge(b3_vpri_r, wbyte, RCR_VOLTAGE_SELECT_PIN_WMASK);
         end
         if (hit(reg_addr, RCR_ADDR_BUCK_THREE_VOLTAGE_SECONDARY)) begin
            b3_vsec_nxt = merge(b3_vsec_r, wbyte, RCR_VOLTAGE_SELECT_PIN_WMASK);
         end
         if (hit(reg_addr, RCR_ADDR_BUCK_THREE_CONTROL)) begin
            b3_ctrl_nxt = merge(b3_ctrl_r, wbyte, RCR_CTRL_WMASK);
         end
         if (hit(reg_addr, RCR_ADDR_LINEAR_ONE_VOLTAGE)) begin
            l1_volt_nxt = merge(l1_volt_r, wbyte, RCR_VOLTAGE_SELECT_PIN_WMASK);
         end
         if (hit(reg_addr, RCR_ADDR_LINEAR_ONE_CONTROL)) begin
            l1_ctrl_nxt = merge(l1_ctrl_r, wbyte, RCR_CTRL_WMASK);
         end
      end
      // lockout wins over a delay code written in the same cycle
      if (undervoltage_lockout_s) begin
         b2_ctrl_nxt[RCR_DELAY_MSB:RCR_DELAY_LSB] =
            RCR_RST_BUCK_TWO_CONTROL[RCR_DELAY_MSB:RCR_DELAY_LSB];
         b3_ctrl_nxt[RCR_DELAY_MSB:RCR_DELAY_LSB] =
            RCR_RST_BUCK_THREE_CONTROL[RCR_DELAY_MSB:RCR_DELAY_LSB];
         l1_ctrl_nxt[RCR_DELAY_MSB:RCR_DELAY_LSB] =
            RCR_RST_LINEAR_ONE_CONTROL[RCR_DELAY_MSB:RCR_DELAY_LSB];
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         b2_ctrl_r <= RCR_RST_BUCK_TWO_CONTROL;
         b3_vpri_r <= RCR_RST_BUCK_THREE_VOLTAGE_PRIMARY;
         b3_vsec_r <= RCR_RST_BUCK_THREE_VOLTAGE_SECONDARY;
         b3_ctrl_r <= RCR_RST_BUCK_THREE_CONTROL;
         l1_volt_r <= RCR_RST_LINEAR_ONE_VOLTAGE;
         l1_ctrl_r <= RCR_RST_LINEAR_ONE_CONTROL;
      end else begin
         b2_ctrl_r <= b2_ctrl_nxt;
         b3_vpri_r <= b3_vpri_nxt;
         b3_vsec_r <= b3_vsec_nxt;
         b3_ctrl_r <= b3_ctrl_nxt;
         l1_volt_r <= l1_volt_nxt;
         l1_ctrl_r <= l1_ctrl_nxt;
      end
   end

   // -----------------------------------------------------------------
   // read path
   // -----------------------------------------------------------------
   rcr_state_type state_r;
   rcr_state_type state_nxt;
   logic [DATA_W-1:0] rdata_r;
   logic [DATA_W-1:0] rdata_nxt;
   logic rvalid_r;
   logic rvalid_nxt;
   logic [7:0] rd_byte;

   always_comb begin
      rd_byte = 8'h00;
      if (hit(reg_addr, RCR_ADDR_BUCK_TWO_CONTROL)) begin
         rd_byte = {b2_ctrl_r[7:1], pok_s[0]};
      end else if (hit(reg_addr, RCR_ADDR_BUCK_THREE_VOLTAGE_PRIMARY)) begin
         rd_byte = {2'b00, b3_vpri_r[5:0]};
      end else if (hit(reg_addr, RCR_ADDR_BUCK_THREE_VOLTAGE_SECONDARY)) begin
         rd_byte = {2'b00, b3_vsec_r[5:0]};
      end else if (hit(reg_addr, RCR_ADDR_BUCK_THREE_CONTROL)) begin
         rd_byte = {b3_ctrl_r[7:1], pok_s[1]};
      end else if (hit(reg_addr, RCR_ADDR_LINEAR_ONE_VOLTAGE)) begin
         rd_byte = {2'b00, l1_volt_r[5:0]};
      end else if (hit(reg_addr, RCR_ADDR_LINEAR_ONE_CONTROL)) begin
         rd_byte = {l1_ctrl_r[7:1], pok_s[2]};
      end
   end

   always_comb begin
      state_nxt = RCR_ST_IDLE;
      rdata_nxt = rdata_r;
      rvalid_nxt = 1'b0;
      case (state_r)
         RCR_ST_IDLE, RCR_ST_WRITE, RCR_ST_READ: begin
            if (reg_rd_en) begin
               state_nxt = RCR_ST_READ;
               rdata_nxt = DATA_W'(rd_byte);
               rvalid_nxt = 1'b1;
            end else if (reg_wr_en) begin
               state_nxt = RCR_ST_WRITE;
            end
         end
         default: begin
            state_nxt = RCR_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_r <= RCR_ST_IDLE;
         rdata_r <= '0;
         rvalid_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         rdata_r <= rdata_nxt;
         rvalid_r <= rvalid_nxt;
      end
   end

   // -----------------------------------------------------------------
   // regulator controls, all registered
   // -----------------------------------------------------------------
   logic [25:0] ctl_r;
   logic [25:0] ctl_nxt;
   logic irq_r;
   logic irq_nxt;

   always_comb begin
      ctl_nxt[0] = b2_ctrl_r[RCR_BIT_ON];
      ctl_nxt[1] = b2_ctrl_r[RCR_BIT_PHASE];
      ctl_nxt[2] = b2_ctrl_r[RCR_BIT_MODE];
      ctl_nxt[5:3] = b2_ctrl_r[RCR_DELAY_MSB:RCR_DELAY_LSB];
      // push-button start only when the option bit is clear
      ctl_nxt[6] = b3_ctrl_r[RCR_BIT_ON]
         | (~b3_ctrl_r[RCR_BIT_PB_OPTION] & pb_s);
      ctl_nxt[7] = b3_ctrl_r[RCR_BIT_MODE];
      ctl_nxt[10:8] = b3_ctrl_r[RCR_DELAY_MSB:RCR_DELAY_LSB];
      ctl_nxt[16:11] = voltage_select_pin_s ? b3_vsec_r[5:0]
                              : b3_vpri_r[5:0];
      ctl_nxt[17] = l1_ctrl_r[RCR_BIT_ON];
      // discharge only acts while the output is shut down
      ctl_nxt[18] = l1_ctrl_r[RCR_BIT_DISCHARGE] & ~l1_ctrl_r[RCR_BIT_ON];
      ctl_nxt[19] = l1_ctrl_r[RCR_BIT_LOW_IQ];
      ctl_nxt[22:20] = l1_ctrl_r[RCR_DELAY_MSB:RCR_DELAY_LSB];
      ctl_nxt[25:23] = '0;
      irq_nxt = (flt_s[0] & b2_ctrl_r[RCR_BIT_FAULT_IRQ])
              | (flt_s[1] & b3_ctrl_r[RCR_BIT_FAULT_IRQ])
              | (flt_s[2] & l1_ctrl_r[RCR_BIT_FAULT_IRQ]);
   end

   logic [RCR_VCODE_W-1:0] l1_code_r;
   logic [RCR_VCODE_W-1:0] l1_code_nxt;

   always_comb begin
      l1_code_nxt = l1_volt_r[RCR_VCODE_W-1:0];
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ctl_r <= '0;
         irq_r <= 1'b0;
         l1_code_r <= '0;
      end else begin
         ctl_r <= ctl_nxt;
         irq_r <= irq_nxt;
         l1_code_r <= l1_code_nxt;
      end
   end

   assign step_down_two_enable = ctl_r[0];
   assign step_down_two_phase_180 = ctl_r[1];
   assign step_down_two_force_pwm = ctl_r[2];
   assign step_down_two_delay = ctl_r[5:3];
   assign step_down_three_enable = ctl_r[6];
   assign step_down_three_force_pwm = ctl_r[7];
   assign step_down_three_delay = ctl_r[10:8];
   assign step_down_three_voltage_code = ctl_r[16:11];
   assign linear_one_enable = ctl_r[17];
   assign linear_one_discharge = ctl_r[18];
   assign linear_one_low_quiescent = ctl_r[19];
   assign linear_one_delay = ctl_r[22:20];
   assign linear_one_voltage_code = l1_code_r;
   assign fault_irq = irq_r;
   assign reg_rdata = rdata_r;
   assign reg_rvalid = rvalid_r;

endmodule

// [rcr_host.sv]
`timescale 1ns/1ps
module rcr_host (
   input wire logic clk_sys,
   output logic reg_wr_en,
   output logic reg_rd_en,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid
);
   initial begin
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end

   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      reg_wr_en = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk_sys);
      reg_wr_en = 1'b0;
      // idle bus shows a changed pattern, so a stale byte can never look valid
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask

   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      int n;
      @(negedge clk_sys);
      reg_rd_en = 1'b1;
      reg_addr = a;
      @(negedge clk_sys);
      reg_rd_en = 1'b0;
      reg_addr = ~a;
      n = 0;
      while (reg_rvalid !== 1'b1 && n < 8) begin
         @(negedge clk_sys);
         n++;
      end
      d = (n < 8) ? reg_rdata : 'x;
   endtask

   task automatic update_field(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
      logic [7:0] d;
      read_reg(a, d);
      write_reg(a, (d & ~m) | (v & m));
   endtask
endmodule

// [rcr_regs_checker.sv]
`timescale 1ns/1ps
module rcr_regs_checker (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic undervoltage_lockout,
   input wire logic [2:0] fault_in,
   input wire logic step_down_two_enable,
   input wire logic step_down_two_phase_180,
   input wire logic [2:0] step_down_two_delay,
   input wire logic [2:0] step_down_three_delay,
   input wire logic linear_one_enable,
   input wire logic linear_one_discharge,
   input wire logic [2:0] linear_one_delay,
   input wire logic [5:0] linear_one_voltage_code,
   input wire logic fault_irq
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   ctrl_write_follows_a: assert property (reg_wr_en && !reg_rd_en && reg_addr == 8'h32 |->
      ##2 {step_down_two_enable, step_down_two_phase_180} == $past(reg_wdata[7:6], 2))
      else $error("step-down two controls did not follow the write");
   code_write_follows_a: assert property (reg_wr_en && !reg_rd_en && reg_addr == 8'h50 |->
      ##2 linear_one_voltage_code == $past(reg_wdata[5:0], 2))
      else $error("linear one voltage code did not follow the write");
   discharge_follows_a: assert property (reg_wr_en && !reg_rd_en && reg_addr == 8'h51 |->
      ##2 {linear_one_enable, linear_one_discharge} ==
      {$past(reg_wdata[7], 2), $past(reg_wdata[6], 2) & ~$past(reg_wdata[7], 2)})
      else $error("linear one enable or discharge wrong");
   reserved_zero_a: assert property (reg_rd_en && (reg_addr == 8'h40 || reg_addr == 8'h41 ||
      reg_addr == 8'h50) |=> reg_rvalid && reg_rdata[7:6] == 2'b00)
      else $error("reserved voltage bits not zero");
   lockout_delay_a: assert property (undervoltage_lockout [*6] |->
      {step_down_two_delay, step_down_three_delay, linear_one_delay} == 9'h000)
      else $error("delay codes not defaulted under lockout");
   fault_quiet_a: assert property ((fault_in == 3'h0) [*5] |-> !fault_irq)
      else $error("fault interrupt without a fault");
   read_answer_a: assert property (reg_rd_en |=> reg_rvalid)
      else $error("read not answered");
   no_spurious_a: assert property (!reg_rd_en |=> !reg_rvalid)
      else $error("read valid without a read");

   cover property (reg_wr_en && reg_addr == 8'h32 && reg_wdata[7]);
   cover property (undervoltage_lockout [*6]);
   cover property ($rose(fault_irq));
endmodule

// [testbench.sv]
`timescale 1ns/1ps
module testbench;
   import rcr_pkg::*;
   logic clk_sys, reset_n, reg_wr_en, reg_rd_en, reg_rvalid, fault_irq;
   logic undervoltage_lockout, voltage_select_pin, pushbutton_input_n;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd, d;
   logic [2:0] power_ok_in, fault_in, sd2_dly, sd3_dly, l1_dly;
   logic sd2_en, sd2_ph, sd2_pwm, sd3_en, sd3_pwm, l1_en, l1_dis, l1_liq;
   logic [5:0] sd3_code, l1_code;
   logic [7:0] shadow [6];
   logic [7:0] map [8] = '{8'h32, 8'h40, 8'h41, 8'h42, 8'h50, 8'h51, 8'h33, 8'hFF};
   int error_cnt, check_count, seed, i, k;

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   rcr_regs uut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_wr_en(reg_wr_en),
      .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .undervoltage_lockout(undervoltage_lockout),
      .voltage_select_pin(voltage_select_pin), .pushbutton_input_n(pushbutton_input_n),
      .power_ok_in(power_ok_in), .fault_in(fault_in), .step_down_two_enable(sd2_en),
      .step_down_two_phase_180(sd2_ph), .step_down_two_force_pwm(sd2_pwm),
      .step_down_two_delay(sd2_dly), .step_down_three_enable(sd3_en),
      .step_down_three_force_pwm(sd3_pwm), .step_down_three_delay(sd3_dly),
      .step_down_three_voltage_code(sd3_code), .linear_one_enable(l1_en),
      .linear_one_discharge(l1_dis), .linear_one_low_quiescent(l1_liq),
      .linear_one_delay(l1_dly), .linear_one_voltage_code(l1_code), .fault_irq(fault_irq));

   rcr_host host (.clk_sys(clk_sys), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

   // ----------------------------------------------------------------
   // expectations
   // ----------------------------------------------------------------
   function automatic logic [7:0] wmask(input int n);
      return (n == 1 || n == 2 || n == 4) ? RCR_VOLTAGE_SELECT_PIN_WMASK : RCR_CTRL_WMASK;
   endfunction

   function automatic logic [7:0] exp_read(input int n);
      if (n > 5) return 8'h00;
      if (wmask(n) == RCR_VOLTAGE_SELECT_PIN_WMASK) return shadow[n];
      return {shadow[n][7:1], power_ok_in[n / 2]};
   endfunction

   function automatic logic [29:0] exp_out();
      return {shadow[0][7:2], shadow[3][7] | (~shadow[3][6] & ~pushbutton_input_n),
         shadow[3][5:2], voltage_select_pin ? shadow[2][5:0] : shadow[1][5:0],
         shadow[5][7], shadow[5][6] & ~shadow[5][7], shadow[5][5:2], shadow[4][5:0],
         |(fault_in & {shadow[5][1], shadow[3][1], shadow[0][1]})};
   endfunction

   task automatic report(input string name, input logic [29:0] expv, input logic [29:0] got);
      check_count++;
      if (got !== expv) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", name, expv, got);
      end
   endtask

   task automatic check_outs();
      report("control outputs", exp_out(), {sd2_en, sd2_ph, sd2_pwm, sd2_dly, sd3_en, sd3_pwm,
         sd3_dly, sd3_code, l1_en, l1_dis, l1_liq, l1_dly, l1_code, fault_irq});
   endtask

   task automatic check_rd(input int n);
      host.read_reg(map[n], rd);
      report("read data", {22'h0, exp_read(n)}, {22'h0, rd});
   endtask

   task automatic do_write(input int n, input logic [7:0] v);
      host.write_reg(map[n], v);
      if (n < 6) shadow[n] = v & wmask(n);
      // lockout wins over a delay code written meanwhile
      if (n < 6 && undervoltage_lockout === 1'b1 && wmask(n) == RCR_CTRL_WMASK) shadow[n][4:2] = 3'h0;
   endtask

   task automatic settle(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   task automatic print_verdict();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------
   initial begin
      seed = 12144;
      error_cnt = 0;
      check_count = 0;
      {reset_n, undervoltage_lockout, voltage_select_pin, pushbutton_input_n} = 4'h1;
      {power_ok_in, fault_in} = 6'h00;
      for (k = 0; k < 6; k++) shadow[k] = 8'h00;
      settle(6);
      reset_n = 1'b1;
      settle(4);
      check_outs();
      for (k = 0; k < 8; k++) check_rd(k);
      for (i = 0; i < 80; i++) begin
         k = (i < 16) ? i % 8 : $unsigned($random(seed)) % 8;
         d = (i < 16) ? ((i < 8) ? 8'hFF : 8'h00) : $random(seed);
         {voltage_select_pin, pushbutton_input_n, power_ok_in, fault_in} = $random(seed);
         do_write(k, d);
         settle(4);
         check_outs();
         check_rd(k);
      end
      host.update_field(8'h42, 8'h1C, 8'h14);
      shadow[3] = ((shadow[3] & 8'hE3) | 8'h14) & RCR_CTRL_WMASK;
      settle(4);
      check_outs();
      undervoltage_lockout = 1'b1;
      settle(6);
      for (k = 0; k < 6; k = k + 1) if (wmask(k) == RCR_CTRL_WMASK) shadow[k][4:2] = 3'h0;
      check_outs();
      do_write(0, 8'h1C);
      settle(4);
      check_outs();
      check_rd(0);
      undervoltage_lockout = 1'b0;
      settle(4);
      do_write(5, 8'h9C);
      settle(4);
      check_outs();
      reset_n = 1'b0;
      settle(2);
      reset_n = 1'b1;
      for (k = 0; k < 6; k++) shadow[k] = 8'h00;
      settle(4);
      check_outs();
      check_rd(3);
      print_verdict();
   end

   initial begin
      #100000;
      error_cnt++;
      print_verdict();
   end
endmodule

bind rcr_regs rcr_regs_checker chk (.clk_sys(clk_sys), .reset_n(reset_n),
   .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .undervoltage_lockout(undervoltage_lockout),
   .fault_in(fault_in), .step_down_two_enable(step_down_two_enable),
   .step_down_two_phase_180(step_down_two_phase_180), .step_down_two_delay(step_down_two_delay),
   .step_down_three_delay(step_down_three_delay), .linear_one_enable(linear_one_enable),
   .linear_one_discharge(linear_one_discharge), .linear_one_delay(linear_one_delay),
   .linear_one_voltage_code(linear_one_voltage_code), .fault_irq(fault_irq));
